// ### hw/threshold_trip_unit.sv
// two-channel threshold trip, duration filter, freezing capture buffers
`timescale 1ns/1ps

// =========================================================================
// Function
// - take one sample per channel every clock
// - sign-extend 14-bit sample into 32-bit buffer word
// - compare each sample with limit and window
// - window counts allowed samples at/above limit
// - trip drives output low, held until cleared
// - both channels monitored by independent copies
// - software reset returns trip output high unless that clock's sample trips
// - readable over-limit flag once trip condition met
// - second output echoes the trigger input
// - tripped channel stops writing its capture buffer
// - software reset unlocks buffer, storing resumes, unless that clock's sample trips
// - parameter banks and sample rams readable by processor
// - four 64K windows at the given bases
module threshold_trip_unit
    import trip_pkg::*;
#(
    parameter int BUF_AW    = 11,               // capture buffer address width
    parameter int BUF_DEPTH = 2048,             // capture buffer words
    parameter int CNT_W     = 16                // window counter width
)(
    input  wire logic                          core_clk,
    input  wire logic                          reset_n,
    // converter samples, one per clock
    input  wire logic [trip_pkg::ADC_W-1:0]    adc_a,
    input  wire logic [trip_pkg::ADC_W-1:0]    adc_b,
    // software settings
    input  wire logic [trip_pkg::DATA_W-1:0]   limit_a,
    input  wire logic [trip_pkg::DATA_W-1:0]   limit_b,
    input  wire logic [CNT_W-1:0]              window_a,
    input  wire logic [CNT_W-1:0]              window_b,
    input  wire logic                          sw_reset_a,
    input  wire logic                          sw_reset_b,
    // trigger in and its echo
    input  wire logic                          trigger_in,
    output logic                               trigger_echo_output,
    // latched trips, active low, and readable flags
    output logic                               trip_output_a_n,
    output logic                               trip_output_b_n,
    output logic                               over_limit_a,
    output logic                               over_limit_b,
    // processor read port into banks and rams
    input  wire logic                          rd_en,
    input  wire logic [31:0]                   rd_addr,
    output logic [trip_pkg::DATA_W-1:0]        rd_data,
    output logic                               rd_valid,
    output logic                               rd_error
);

    // =====================================================================
    // per-channel views of the separate ports
    // =====================================================================
    logic [ADC_W-1:0]  adc_v      [NCH];        // raw samples
    logic [DATA_W-1:0] limit_v    [NCH];        // signed limits
    logic [CNT_W-1:0]  window_v   [NCH];        // allowed counts
    logic              sw_reset_v [NCH];        // software reset pulses

    always_comb
    begin
        adc_v[0]      = adc_a;
        adc_v[1]      = adc_b;
        limit_v[0]    = limit_a;
        limit_v[1]    = limit_b;
        window_v[0]   = window_a;
        window_v[1]   = window_b;
        sw_reset_v[0] = sw_reset_a;
        sw_reset_v[1] = sw_reset_b;
    end

    // =====================================================================
    // trip state
    // =====================================================================
    logic [CNT_W-1:0]  cnt_reg    [NCH];        // consecutive over-limit samples
    logic [CNT_W-1:0]  cnt_next   [NCH];
    logic              trip_reg   [NCH];        // latched trip, also freezes buffer
    logic              trip_next  [NCH];
    logic [BUF_AW-1:0] wptr_reg   [NCH];        // wrapping buffer write address
    logic [BUF_AW-1:0] wptr_next  [NCH];
    logic [DATA_W-1:0] word_c     [NCH];        // extended sample this clock
    logic              wr_en_c    [NCH];        // buffer write this clock
    logic              echo_next;

    // counter that sticks at its top instead of wrapping back to zero
    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        return (v == {CNT_W{1'b1}}) ? v : v + 1'b1;
    endfunction : sat_inc

    // next trip state for both channels; the same logic is repeated per channel
    always_comb
    begin
        logic [CNT_W-1:0] cnt_base;
        logic             trip_base;
        logic             above;
        cnt_base  = '0;
        trip_base = 1'b0;
        above     = 1'b0;
        for (int c = 0; c < NCH; c++)
        begin
            word_c[c] = sign_extend(adc_v[c]);
            // a software reset takes effect on this same clock's sample, so a
            // sample that trips in that clock still trips: the set wins
            cnt_base  = sw_reset_v[c] ? '0 : cnt_reg[c];
            trip_base = sw_reset_v[c] ? 1'b0 : trip_reg[c];
            above     = $signed(word_c[c]) >= $signed(limit_v[c]);
            if (above)
            begin
                cnt_next[c] = sat_inc(cnt_base);
            end
            else
            begin
                cnt_next[c] = '0;
            end
            // trip once more samples than the window allows were above
            trip_next[c] = trip_base | (above && (cnt_next[c] > window_v[c]));
            // the tripping sample itself is kept out so the buffer stays pre-trip
            wr_en_c[c]   = !trip_next[c];
            wptr_next[c] = wr_en_c[c] ? wptr_reg[c] + 1'b1 : wptr_reg[c];
        end
        echo_next = trigger_in;
    end

    // register trip state and the pin images
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int c = 0; c < NCH; c++)
            begin
                cnt_reg[c]  <= '0;
                trip_reg[c] <= 1'b0;
                wptr_reg[c] <= '0;
            end
            trip_output_a_n     <= 1'b1;
            trip_output_b_n     <= 1'b1;
            over_limit_a        <= 1'b0;
            over_limit_b        <= 1'b0;
            trigger_echo_output <= 1'b0;
        end
        else
        begin
            // one sample accepted per channel on every clock
            for (int c = 0; c < NCH; c++)
            begin
                cnt_reg[c]  <= cnt_next[c];
                trip_reg[c] <= trip_next[c];
                wptr_reg[c] <= wptr_next[c];
            end
            trip_output_a_n     <= !trip_next[0];
            trip_output_b_n     <= !trip_next[1];
            over_limit_a        <= trip_next[0];
            over_limit_b        <= trip_next[1];
            trigger_echo_output <= echo_next;
        end
    end

    // =====================================================================
    // capture buffers
    // =====================================================================
    // no reset on the array: contents are only meaningful after writes
    logic [DATA_W-1:0] buf_mem [NCH][BUF_DEPTH];

    always_ff @(posedge core_clk)
    begin
        for (int c = 0; c < NCH; c++)
        begin
            if (reset_n && wr_en_c[c])
            begin
                buf_mem[c][wptr_reg[c]] <= word_c[c];
            end
        end
    end

    // =====================================================================
    // processor read port
    // =====================================================================
    logic [DATA_W-1:0] rd_data_next;
    logic              rd_valid_next;
    logic              rd_error_next;

    // bank word for one channel at a bank offset; miss flags unmapped words
    function automatic logic [DATA_W-1:0] bank_word(
        input logic [15:0]        ofs,
        input logic [DATA_W-1:0]  lim,
        input logic [CNT_W-1:0]   win,
        input logic               tripped,
        input logic [BUF_AW-1:0]  wptr,
        output logic              miss
    );
        logic [DATA_W-1:0] w;
        w    = '0;
        miss = 1'b0;
        case (ofs)
            PAR_LIMIT_OFS:  w = lim;
            PAR_WINDOW_OFS: w = DATA_W'(win);
            PAR_STATUS_OFS:
            begin
                w[ST_TRIP_BIT]   = tripped;
                w[ST_FROZEN_BIT] = tripped;
            end
            PAR_WPTR_OFS:   w = DATA_W'(wptr);
            default:        miss = 1'b1;
        endcase
        return w;
    endfunction : bank_word

    // decode the address and pick the word to return next clock
    always_comb
    begin
        logic        miss;
        logic [13:0] widx;
        miss          = 1'b0;
        widx          = rd_addr[15:WORD_LSB];
        rd_data_next  = '0;
        rd_valid_next = rd_en;
        case (decode_window(rd_addr))
            WIN_BANK_A: rd_data_next = bank_word(rd_addr[15:0], limit_v[0], window_v[0],
                                                 trip_reg[0], wptr_reg[0], miss);
            WIN_BANK_B: rd_data_next = bank_word(rd_addr[15:0], limit_v[1], window_v[1],
                                                 trip_reg[1], wptr_reg[1], miss);
            WIN_RAM_A, WIN_RAM_B:
            begin
                if (32'(widx) < 32'(BUF_DEPTH))
                begin
                    rd_data_next = (decode_window(rd_addr) == WIN_RAM_A)
                                 ? buf_mem[0][widx[BUF_AW-1:0]]
                                 : buf_mem[1][widx[BUF_AW-1:0]];
                end
                else
                begin
                    miss = 1'b1;                                       // beyond buffer depth
                end
            end
            default:    miss = 1'b1;                                   // outside all windows
        endcase
        rd_error_next = rd_en & miss;
        if (!rd_en)
        begin
            rd_data_next = '0;                                         // quiet bus when idle
        end
    end

    // register the read answer
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rd_data  <= '0;
            rd_valid <= 1'b0;
            rd_error <= 1'b0;
        end
        else
        begin
            rd_data  <= rd_data_next;
            rd_valid <= rd_valid_next;
            rd_error <= rd_error_next;
        end
    end

endmodule : threshold_trip_unit

// ### hw/trip_pkg.sv
// shared constants, address map and helpers for the threshold trip unit
package trip_pkg;

    // =====================================================================
    // data widths
    // =====================================================================
    localparam int ADC_W  = 14;                 // raw converter sample width
    localparam int DATA_W = 32;                 // sign-extended buffer word
    localparam int NCH    = 2;                  // monitored input channels

    // =====================================================================
    // sampling timing
    // =====================================================================
    localparam int SAMPLE_RATE_MHZ  = 125;      // nominal converter rate
    localparam int SAMPLE_PERIOD_NS = 1000 / SAMPLE_RATE_MHZ;  // 8 ns
    localparam int CORE_CLK_MHZ     = 40;       // rate this build is clocked at
    localparam int CORE_PERIOD_NS   = 1000 / CORE_CLK_MHZ;     // 25 ns

    // =====================================================================
    // processor address map: four consecutive 64K windows
    // =====================================================================
    localparam logic [31:0] WIN_SIZE    = 32'h0001_0000;
    localparam logic [31:0] WIN_MASK    = 32'hffff_0000;
    localparam logic [31:0] BANK_A_BASE = 32'h43c0_0000;
    localparam logic [31:0] BANK_B_BASE = BANK_A_BASE + WIN_SIZE;
    localparam logic [31:0] RAM_A_BASE  = 32'h43c2_0000;
    localparam logic [31:0] RAM_B_BASE  = RAM_A_BASE + WIN_SIZE;

    // parameter bank word offsets inside a bank window
    localparam logic [15:0] PAR_LIMIT_OFS  = 16'h0000;
    localparam logic [15:0] PAR_WINDOW_OFS = 16'h0004;
    localparam logic [15:0] PAR_STATUS_OFS = 16'h0008;
    localparam logic [15:0] PAR_WPTR_OFS   = 16'h000c;

    // status word layout
    localparam int ST_TRIP_BIT   = 0;
    localparam int ST_FROZEN_BIT = 1;

    // byte lane bits dropped to form a word index
    localparam int WORD_LSB = 2;

    // which window an address falls in
    typedef enum logic [2:0] {
        WIN_BANK_A,
        WIN_BANK_B,
        WIN_RAM_A,
        WIN_RAM_B,
        WIN_NONE
    } win_e;

    // =====================================================================
    // helpers
    // =====================================================================
    // map a processor address onto one of the four windows
    function automatic win_e decode_window(input logic [31:0] addr);
        win_e w;
        w = WIN_NONE;
        case (addr & WIN_MASK)
            BANK_A_BASE: w = WIN_BANK_A;
            BANK_B_BASE: w = WIN_BANK_B;
            RAM_A_BASE:  w = WIN_RAM_A;
            RAM_B_BASE:  w = WIN_RAM_B;
            default:     w = WIN_NONE;
        endcase
        return w;
    endfunction : decode_window

    // widen a converter sample keeping its sign
    function automatic logic [DATA_W-1:0] sign_extend(input logic [ADC_W-1:0] s);
        return {{(DATA_W-ADC_W){s[ADC_W-1]}}, s};
    endfunction : sign_extend

endpackage : trip_pkg

// ### test/adc_front_end.sv
// behavioural converter front end feeding both sample inputs
`timescale 1ns/1ps

// =====================================================================
// converter model
// =====================================================================
module adc_front_end
    import trip_pkg::*;
(
    input  wire logic [trip_pkg::ADC_W-1:0] level_a,
    input  wire logic [trip_pkg::ADC_W-1:0] level_b,
    output logic      [trip_pkg::ADC_W-1:0] adc_a,
    output logic      [trip_pkg::ADC_W-1:0] adc_b
);
    // output tracks the input level; the bench steps it off the sampling edge
    // so every rising edge sees one settled word per channel
    assign adc_a = level_a;
    assign adc_b = level_b;
endmodule : adc_front_end

// ### test/threshold_trip_unit_bench.sv
// self-checking bench for the threshold trip unit
`timescale 1ns/1ps

// =====================================================================
// bench top
// =====================================================================
module threshold_trip_unit_bench;
    import trip_pkg::*;
    localparam int AW = 4;                      // small buffer keeps the wrap visible
    localparam int DEPTH = 16;                  // must stay 2**AW
    logic              core_clk = 1'b0;
    logic              reset_n = 1'b0;
    logic [ADC_W-1:0]  level_a = '0;
    logic [ADC_W-1:0]  level_b = '0;
    logic [ADC_W-1:0]  adc_a, adc_b;
    logic [DATA_W-1:0] limit_a = 32'h0000_0064;  // 100
    logic [DATA_W-1:0] limit_b = 32'h0000_1000;  // above idle level, no early trip
    logic [15:0]       window_a = 16'h0002;
    logic [15:0]       window_b = 16'h0000;
    logic              sw_reset_a = 1'b0, sw_reset_b = 1'b0, trigger_in = 1'b0;
    logic              trigger_echo_output, trip_output_a_n, trip_output_b_n;
    logic              over_limit_a, over_limit_b, rd_valid, rd_error;
    logic              rd_en = 1'b0;
    logic [31:0]       rd_addr = '0;
    logic [DATA_W-1:0] rd_data;
    int                err_count = 0;
    int                samples_checked = 0;

    always #12.5 core_clk = ~core_clk;

    adc_front_end fe (.level_a, .level_b, .adc_a, .adc_b);
    threshold_trip_unit #(.BUF_AW(AW), .BUF_DEPTH(DEPTH)) dut (.core_clk, .reset_n, .adc_a,
        .adc_b, .limit_a, .limit_b, .window_a, .window_b, .sw_reset_a, .sw_reset_b,
        .trigger_in, .trigger_echo_output, .trip_output_a_n, .trip_output_b_n,
        .over_limit_a, .over_limit_b, .rd_en, .rd_addr, .rd_data, .rd_valid, .rd_error);

    // =================================================================
    // helpers
    // =================================================================
    // below-limit ramp, negative first half to exercise widening
    function automatic logic [ADC_W-1:0] ramp(input int j);
        return ADC_W'(j * 8 - 80);
    endfunction : ramp

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one sample per channel, taken at the next rising edge
    task automatic step(input logic [ADC_W-1:0] va, input logic [ADC_W-1:0] vb);
        @(negedge core_clk);
        level_a = va;
        level_b = vb;
    endtask : step

    // one read; answer stands only in the following cycle
    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic er);
        @(negedge core_clk);
        rd_en = 1'b1;
        rd_addr = a;
        @(negedge core_clk);
        rd_en = 1'b0;
        chk(32'({rd_valid, rd_error}), 32'({1'b1, er}));
        chk(rd_data, exp);
    endtask : rd

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    // =================================================================
    // tests
    // =================================================================
    initial
    begin
        logic [ADC_W-1:0] s;
        int j;
        repeat (12) @(negedge core_clk);
        reset_n = 1'b1;
        chk(32'({trip_output_a_n, trip_output_b_n, over_limit_a, over_limit_b}), 32'hc);
        trigger_in = 1'b1;
        @(negedge core_clk);
        chk(32'(trigger_echo_output), 32'h1);
        trigger_in = 1'b0;
        @(negedge core_clk);
        chk(32'(trigger_echo_output), 32'h0);
        $display("test reset_echo done");
        // a low sample between runs must restart the count
        step(14'h0096, '0); step(14'h0096, '0); step(14'h0032, '0);
        step(14'h0096, '0); step(14'h0096, '0);
        for (j = 0; j < 20; j++) step(ramp(j), '0);
        chk(32'(trip_output_a_n), 32'h1);
        step(14'h0096, '0); step(14'h0096, '0); step(14'h0096, '0);
        chk(32'(trip_output_a_n), 32'h1);
        @(negedge core_clk);
        chk(32'({trip_output_a_n, over_limit_a, trip_output_b_n}), 32'h3);
        $display("test filter done");
        // frozen buffer: 3 idle, 5 filter, 20 ramp and 2 pre-trip words went in (30 writes),
        // so word k holds write 16+k for k < 14 and write k above; pointer stops at 14
        for (j = 0; j < DEPTH; j++)
        begin
            s = (j < 12) ? ramp(j + 8) : ((j < 14) ? 14'h0096 : ramp(j - 8));
            rd(RAM_A_BASE + 32'(j * 4), {{(DATA_W-ADC_W){s[ADC_W-1]}}, s}, 1'b0);
        end
        rd(BANK_A_BASE + 32'(PAR_STATUS_OFS), 32'h3, 1'b0);
        rd(BANK_A_BASE + 32'(PAR_WPTR_OFS), 32'he, 1'b0);
        rd(BANK_A_BASE + 32'(PAR_LIMIT_OFS), 32'h64, 1'b0);
        rd(BANK_A_BASE + 32'(PAR_WINDOW_OFS), 32'h2, 1'b0);
        rd(RAM_B_BASE + 32'h14, 32'h0, 1'b0);
        rd(BANK_B_BASE + 32'h10, 32'h0, 1'b1);
        rd(32'h43c4_0000, 32'h0, 1'b1);
        rd(RAM_A_BASE + 32'(DEPTH * 4), 32'h0, 1'b1);
        $display("test frozen_read done");
        step('0, '0);
        sw_reset_a = 1'b1;
        @(negedge core_clk);
        sw_reset_a = 1'b0;
        chk(32'({trip_output_a_n, over_limit_a}), 32'h2);
        rd(BANK_A_BASE + 32'(PAR_STATUS_OFS), 32'h0, 1'b0);
        // word 14 took the first sample after release and is not yet overwritten
        rd(RAM_A_BASE + 32'h38, 32'h0, 1'b0);
        $display("test release done");
        // channel b: window zero, negative limit, trip beats a same-cycle reset
        // lower the level first: an idle zero would already sit above the new limit
        level_b = 14'h3ffa;
        limit_b = 32'hffff_fffb;
        step('0, 14'h3ffa); step('0, 14'h3ffa);
        chk(32'(trip_output_b_n), 32'h1);
        step('0, 14'h3ffc);
        @(negedge core_clk);
        chk(32'({trip_output_b_n, over_limit_b}), 32'h1);
        sw_reset_b = 1'b1;
        @(negedge core_clk);
        chk(32'(trip_output_b_n), 32'h0);
        level_b = 14'h3ffa;
        @(negedge core_clk);
        sw_reset_b = 1'b0;
        chk(32'({trip_output_b_n, trip_output_a_n}), 32'h3);
        $display("test channel_b done");
        tally_and_finish();
    end

    // cut a hang short well past the expected hundred or so cycles
    initial
    begin
        #100000;
        err_count++;
        tally_and_finish();
    end
endmodule : threshold_trip_unit_bench

// ### test/trip_checker_properties.sv
// concurrent checks on the threshold trip unit ports
`timescale 1ns/1ps

// =====================================================================
// checker
// =====================================================================
module trip_checker
    import trip_pkg::*;
#(
    parameter int CNT_W = 16                    // window counter width
)(
    input wire logic                        core_clk,
    input wire logic                        reset_n,
    input wire logic [trip_pkg::ADC_W-1:0]  adc_a,
    input wire logic [trip_pkg::ADC_W-1:0]  adc_b,
    input wire logic [trip_pkg::DATA_W-1:0] limit_a,
    input wire logic [trip_pkg::DATA_W-1:0] limit_b,
    input wire logic [CNT_W-1:0]            window_a,
    input wire logic [CNT_W-1:0]            window_b,
    input wire logic                        sw_reset_a,
    input wire logic                        sw_reset_b,
    input wire logic                        trigger_in,
    input wire logic                        trigger_echo_output,
    input wire logic                        trip_output_a_n,
    input wire logic                        trip_output_b_n,
    input wire logic                        over_limit_a,
    input wire logic                        over_limit_b,
    input wire logic                        rd_en,
    input wire logic [31:0]                 rd_addr,
    input wire logic [trip_pkg::DATA_W-1:0] rd_data,
    input wire logic                        rd_valid,
    input wire logic                        rd_error
);
    logic ge_a;                                 // channel a sample at/above limit
    logic ge_b;                                 // channel b sample at/above limit
    // signed compare after widening, as the trip path sees it
    assign ge_a = $signed({{(DATA_W-ADC_W){adc_a[ADC_W-1]}}, adc_a}) >= $signed(limit_a);
    assign ge_b = $signed({{(DATA_W-ADC_W){adc_b[ADC_W-1]}}, adc_b}) >= $signed(limit_b);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_echo_copy: assert property (1'b1 |=> trigger_echo_output == $past(trigger_in))
        else $error("echo does not follow trigger");
    a_flag_inverse: assert property ((over_limit_a != trip_output_a_n) &&
        (over_limit_b != trip_output_b_n)) else $error("flag not inverse of trip");
    a_trip_latch_a: assert property (!trip_output_a_n && !sw_reset_a |=> !trip_output_a_n)
        else $error("trip a released without reset");
    a_trip_latch_b: assert property (!trip_output_b_n && !sw_reset_b |=> !trip_output_b_n)
        else $error("trip b released without reset");
    a_release_a: assert property (sw_reset_a && !ge_a |=> trip_output_a_n)
        else $error("reset did not release trip a");
    a_low_no_trip: assert property (!ge_a && trip_output_a_n |=> trip_output_a_n)
        else $error("trip a on sample below limit");
    a_zero_window_b: assert property (window_b == '0 && ge_b |=> !trip_output_b_n)
        else $error("window zero did not trip b");
    a_read_answer: assert property (rd_en |=> rd_valid ##1 !rd_valid || $past(rd_en))
        else $error("read answer not one cycle");
    a_idle_quiet: assert property (!rd_en |=> !rd_valid && rd_data == '0)
        else $error("read outputs active without request");
    a_unmapped_err: assert property (rd_en && rd_addr[31:18] != 14'h10f0 |=>
        rd_error && rd_data == '0) else $error("unmapped read not refused");
endmodule : trip_checker

bind threshold_trip_unit trip_checker #(.CNT_W(CNT_W)) checker_i (.core_clk, .reset_n,
    .adc_a, .adc_b, .limit_a, .limit_b, .window_a, .window_b, .sw_reset_a, .sw_reset_b,
    .trigger_in, .trigger_echo_output, .trip_output_a_n, .trip_output_b_n, .over_limit_a,
    .over_limit_b, .rd_en, .rd_addr, .rd_data, .rd_valid, .rd_error);
